// >>> dccu_pkg.sv
// dccu_pkg: shared constants and types for the disk control command unit
package dccu_pkg;
  // command codes presented on cmd_code
  typedef enum logic [3:0] {
    DCCU_CMD_NONE     = 4'h0,
    DCCU_CMD_RECAL    = 4'h1,
    DCCU_CMD_SEEK     = 4'h2,
    DCCU_CMD_RELSEEK  = 4'h3,
    DCCU_CMD_READID   = 4'h4,
    DCCU_CMD_SENSEINT = 4'h5,
    DCCU_CMD_SENSEDRV = 4'h6,
    DCCU_CMD_SPECIFY  = 4'h7,
    DCCU_CMD_CONFIG   = 4'h8,
    DCCU_CMD_VERSION  = 4'h9,
    DCCU_CMD_RWDONE   = 4'ha
  } dccu_cmd_t;

  // positioning engine states, one-hot
  typedef enum logic [3:0] {
    DCCU_IDLE  = 4'b0001,
    DCCU_STEP  = 4'b0010,
    DCCU_WAIT  = 4'b0100,
    DCCU_DONE  = 4'b1000
  } dccu_state_t;

  // termination codes
  localparam logic [1:0] DCCU_TC_NORMAL = 2'h0;
  localparam logic [1:0] DCCU_TC_ABNORMAL = 2'h1;
  localparam logic [1:0] DCCU_TC_POLL = 2'h3;

  // status zero bit positions
  localparam int DCCU_ST0_SE = 5;
  localparam int DCCU_ST0_EC = 4;
  localparam int DCCU_ST0_HD = 2;

  // fixed version result byte (arbitrary value marking the enhanced type)
  localparam logic [7:0] DCCU_VERSION_BYTE = 8'ha5;

  // recalibrate step limit
  localparam logic [6:0] DCCU_RECAL_MAX = 7'h4f;

  // configure defaults
  localparam logic DCCU_DEF_AUTO_SEEK = 1'b0;
  localparam logic DCCU_DEF_QUEUE_DIS = 1'b1;
  localparam logic DCCU_DEF_POLL_DIS = 1'b0;
  localparam logic [3:0] DCCU_DEF_THRESH = 4'h0;
  localparam logic [7:0] DCCU_DEF_PRECOMP = 8'h00;

  // timing at 250 kbps: ms per code unit for step, unload, settle
  localparam int DCCU_CLK_HZ = 25_000_000;
  localparam int DCCU_STEP_UNIT_MS = 2;
  localparam int DCCU_UNLOAD_UNIT_MS = 32;
  localparam int DCCU_SETTLE_UNIT_MS = 4;
  localparam int DCCU_STEP_UNIT_CYC = DCCU_CLK_HZ / 1000 * DCCU_STEP_UNIT_MS;
  localparam int DCCU_UNLOAD_UNIT_CYC = DCCU_CLK_HZ / 1000 * DCCU_UNLOAD_UNIT_MS;
  localparam int DCCU_SETTLE_UNIT_CYC = DCCU_CLK_HZ / 1000 * DCCU_SETTLE_UNIT_MS;
  // step pulse width in cycles
  localparam int DCCU_PULSE_CYC = 4;
  // codes of zero stand for this many units
  localparam logic [4:0] DCCU_STEP_ZERO_UNITS = 5'h10;
  localparam logic [4:0] DCCU_UNLOAD_ZERO_UNITS = 5'h10;
  localparam logic [7:0] DCCU_SETTLE_ZERO_UNITS = 8'h80;
endpackage

// >>> dccu_timer.sv
// dccu_timer: scaled delay counter, units of base cycles shifted by data rate
module dccu_timer
  import dccu_pkg::*;
#(
  parameter int UNIT_CYC = 50000,
  parameter int CW = 32
) (
  input wire logic clk,             // system clock
  input wire logic rst_n,           // async reset, active low
  input wire logic clk_en,          // freeze when low
  input wire logic start,           // load and run
  input wire logic [7:0] units,     // delay in code units
  input wire logic [1:0] rate_shift, // 0=250k,1=500k,2=1M,3=2M
  output logic busy                 // high while counting
);
  logic [CW-1:0] cnt_q;

  // units times unit length, halved per doubling of rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (start) begin
        cnt_q <= CW'((64'(units) * 64'(UNIT_CYC)) >> rate_shift);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CW'(1);
      end
    end
  end

  assign busy = (cnt_q != '0);
endmodule

// >>> dccu_core.sv
// dccu_core: control command execution for the disk controller
module dccu_core
  import dccu_pkg::*;
#(
  parameter int RECAL_STEPS = 79
) (
  input wire logic clk,                       // 25 MHz clock
  input wire logic rst_n,                     // async reset, active low
  input wire logic clk_en,                    // freezes all state when low
  input wire logic cmd_valid,                 // command issue strobe
  input wire dccu_cmd_t cmd_code,             // command selector
  input wire logic [7:0] cmd_arg0,            // target_track / relative_track_count / timing code
  input wire logic [7:0] cmd_arg1,            // direction bit 0 / settle code / config bits
  input wire logic [7:0] cmd_arg2,            // precomp_start_track for configure
  input wire logic [1:0] rate_shift,          // data rate: 0=250k .. 3=2M
  input wire logic track_zero_input,          // high when head at track zero
  input wire logic rotation_marker_input,     // index pulse, high active
  input wire logic id_found,                  // id field seen by reader
  input wire logic [7:0] id_track,            // track of that id field
  input wire logic [7:0] drive_status_in,     // drive status byte
  input wire logic powerdown_exit,            // pulse on leaving powerdown
  input wire logic rw_byte_need,              // reader wants a byte moved
  output logic step_out,                      // step pulse to drive
  output logic dir_out,                       // 1 step in, 0 step out
  output logic busy,                          // command phase busy
  output logic drive_busy,                    // positioning not yet sensed
  output logic irq,                           // interrupt request
  output logic result_valid,                  // result byte strobe
  output logic [7:0] result_byte,             // result data
  output logic [7:0] current_track_reg,       // present track
  output logic [7:0] status_zero,             // status zero
  output logic missing_id_flag,               // no id found
  output logic request_for_master,            // program IO byte request
  output logic transfer_irq_pin,              // program IO transfer irq
  output logic dma_request_pin,               // dma request
  output logic head_loaded,                   // head unload delay running
  output logic settle_busy,                   // head settle timer busy; the timer is never started, so this stays low
  output logic auto_seek_enable,              // implied seek setting
  output logic queue_disable,                 // queue off, byte requests
  output logic [4:0] queue_threshold_bytes,   // threshold 1..16
  output logic [7:0] precomp_start_track,     // precomp start track
  output logic program_io_select              // 1 program IO, 0 dma
);
  dccu_state_t state_q;
  logic [7:0] target_track_q;
  logic [7:0] steps_left_q;
  logic [6:0] recal_cnt_q;
  logic mode_recal_q, mode_rel_q;
  logic [3:0] step_code_q, unload_code_q;
  logic [6:0] settle_code_q;
  logic poll_disable_q;
  logic [3:0] queue_threshold_q;
  logic [2:0] pulse_q;
  logic [1:0] index_cnt_q;
  logic readid_q, idx_prev_q, poll_pend_q;
  logic step_t_busy, unload_busy;
  logic step_t_start, unload_start, settle_start;
  logic [7:0] step_units, unload_units, settle_units;

  // zero code stands for the longest setting
  function automatic logic [7:0] code_units(input logic [6:0] code, input logic [7:0] zero_val);
    code_units = (code == 7'h00) ? zero_val : {1'b0, code};
  endfunction

  // step code F gives 1 unit (2 ms), 0 gives 16 units (32 ms)
  // step scaling
  assign step_units = code_units(7'(5'h10 - {1'b0, step_code_q}), {3'h0, DCCU_STEP_ZERO_UNITS});
  assign unload_units = code_units({3'h0, unload_code_q}, {3'h0, DCCU_UNLOAD_ZERO_UNITS});
  assign settle_units = code_units(settle_code_q, DCCU_SETTLE_ZERO_UNITS);

  dccu_timer #(.UNIT_CYC(DCCU_STEP_UNIT_CYC), .CW(32)) u_step_timer (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(step_t_start),
    .units(step_units), .rate_shift(rate_shift), .busy(step_t_busy));
  dccu_timer #(.UNIT_CYC(DCCU_UNLOAD_UNIT_CYC), .CW(32)) u_unload_timer (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(unload_start),
    .units(unload_units), .rate_shift(rate_shift), .busy(unload_busy));
  dccu_timer #(.UNIT_CYC(DCCU_SETTLE_UNIT_CYC), .CW(32)) u_settle_timer (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(settle_start),
    .units(settle_units), .rate_shift(rate_shift), .busy(settle_busy));

  logic take;
  assign take = cmd_valid & clk_en;
  assign unload_start = take && cmd_code == DCCU_CMD_RWDONE;
  // settle timer is never started: its start term is ANDed with a constant zero
  assign settle_start = take && cmd_code == DCCU_CMD_RWDONE && 1'b0;
  assign step_t_start = (state_q == DCCU_STEP) && pulse_q == 3'(DCCU_PULSE_CYC - 1);
  assign head_loaded = unload_busy;

  // specify and configure registers
  // defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_code_q <= 4'h0;
      unload_code_q <= 4'h0;
      settle_code_q <= 7'h00;
      program_io_select <= 1'b0;
      auto_seek_enable <= DCCU_DEF_AUTO_SEEK;
      queue_disable <= DCCU_DEF_QUEUE_DIS;
      poll_disable_q <= DCCU_DEF_POLL_DIS;
      queue_threshold_q <= DCCU_DEF_THRESH;
      precomp_start_track <= DCCU_DEF_PRECOMP;
    end else if (take && cmd_code == DCCU_CMD_SPECIFY) begin
      step_code_q <= cmd_arg0[7:4];
      unload_code_q <= cmd_arg0[3:0];
      settle_code_q <= cmd_arg1[7:1];
      program_io_select <= cmd_arg1[0];
    end else if (take && cmd_code == DCCU_CMD_CONFIG) begin
      auto_seek_enable <= cmd_arg1[6];
      queue_disable <= cmd_arg1[5];
      poll_disable_q <= cmd_arg1[4];
      queue_threshold_q <= cmd_arg1[3:0];
      precomp_start_track <= cmd_arg2;
    end
  end

  // code 0 is one byte, F is sixteen
  assign queue_threshold_bytes = {1'b0, queue_threshold_q} + 5'h01;

  // transfer requests, dma or program IO
  // route requests
  // byte-wise while queue disabled (one request per byte need)
  assign request_for_master = rw_byte_need & program_io_select;
  assign transfer_irq_pin = rw_byte_need & program_io_select;
  assign dma_request_pin = rw_byte_need & ~program_io_select;

  // positioning engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DCCU_IDLE;
      current_track_reg <= 8'h00;
      target_track_q <= 8'h00;
      steps_left_q <= 8'h00;
      recal_cnt_q <= 7'h00;
      mode_recal_q <= 1'b0;
      mode_rel_q <= 1'b0;
      dir_out <= 1'b0;
      pulse_q <= 3'h0;
    end else if (clk_en) begin
      if (powerdown_exit) begin
        current_track_reg <= 8'h00;
        state_q <= DCCU_IDLE;
      end else begin
        case (state_q)
          DCCU_IDLE: begin
            if (take && cmd_code == DCCU_CMD_RECAL) begin
              current_track_reg <= 8'h00;
              dir_out <= 1'b0;
              mode_recal_q <= 1'b1;
              mode_rel_q <= 1'b0;
              recal_cnt_q <= 7'h00;
              state_q <= DCCU_WAIT;
            end else if (take && cmd_code == DCCU_CMD_SEEK) begin
              dir_out <= (cmd_arg0 > current_track_reg);
              target_track_q <= cmd_arg0;
              mode_recal_q <= 1'b0;
              mode_rel_q <= 1'b0;
              state_q <= DCCU_WAIT;
            end else if (take && cmd_code == DCCU_CMD_RELSEEK) begin
              dir_out <= cmd_arg1[0];
              steps_left_q <= cmd_arg0;
              mode_recal_q <= 1'b0;
              mode_rel_q <= 1'b1;
              state_q <= DCCU_WAIT;
            end
          end
          DCCU_WAIT: begin
            if (!step_t_busy) begin
              if (mode_recal_q) begin
                if (track_zero_input || recal_cnt_q == 7'(RECAL_STEPS)) begin
                  state_q <= DCCU_DONE;
                end else begin
                  state_q <= DCCU_STEP;
                end
              end else if (mode_rel_q) begin
                state_q <= (steps_left_q == 8'h00) ? DCCU_DONE : DCCU_STEP;
              end else begin
                state_q <= (target_track_q == current_track_reg) ? DCCU_DONE : DCCU_STEP;
              end
              pulse_q <= 3'h0;
            end
          end
          DCCU_STEP: begin
            pulse_q <= pulse_q + 3'h1;
            if (pulse_q == 3'(DCCU_PULSE_CYC - 1)) begin
              state_q <= DCCU_WAIT;
              if (mode_recal_q) begin
                recal_cnt_q <= recal_cnt_q + 7'h01;
              end else if (mode_rel_q) begin
                steps_left_q <= steps_left_q - 8'h01;
                current_track_reg <= dir_out ? current_track_reg + 8'h01 : current_track_reg - 8'h01;
              end else begin
                current_track_reg <= dir_out ? current_track_reg + 8'h01 : current_track_reg - 8'h01;
              end
            end
          end
          DCCU_DONE: begin
            state_q <= DCCU_IDLE;
          end
          default: begin
            state_q <= DCCU_IDLE;
          end
        endcase
      end
    end
  end

  assign step_out = (state_q == DCCU_STEP);
  // busy only while a command is taken
  assign busy = take;

  // status, interrupt and drive busy tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_zero <= 8'h00;
      irq <= 1'b0;
      drive_busy <= 1'b0;
      poll_pend_q <= 1'b1;
      missing_id_flag <= 1'b0;
      readid_q <= 1'b0;
      index_cnt_q <= 2'h0;
      idx_prev_q <= 1'b0;
    end else if (clk_en) begin
      idx_prev_q <= rotation_marker_input;
      if (powerdown_exit) begin
        status_zero <= 8'h00;
        missing_id_flag <= 1'b0;
        drive_busy <= 1'b0;
      end else begin
        // single poll interrupt, held off while head loaded
        if (poll_pend_q && !poll_disable_q && !unload_busy) begin
          poll_pend_q <= 1'b0;
          irq <= 1'b1;
          status_zero <= {DCCU_TC_POLL, 6'h00};
        end
        if (take && (cmd_code == DCCU_CMD_RECAL || cmd_code == DCCU_CMD_SEEK || cmd_code == DCCU_CMD_RELSEEK)) begin
          drive_busy <= 1'b1;
          // stale fault from an earlier command must not leak into this one
          status_zero[DCCU_ST0_EC] <= 1'b0;
        end
        if (state_q == DCCU_DONE) begin
          irq <= 1'b1;
          status_zero <= 8'h00;
          status_zero[DCCU_ST0_SE] <= 1'b1;
          if (mode_recal_q && !track_zero_input) begin
            status_zero[7:6] <= DCCU_TC_ABNORMAL;
            status_zero[DCCU_ST0_EC] <= 1'b1;
          end
          // keep a fault raised while stepping out past zero
          if (mode_rel_q && status_zero[DCCU_ST0_EC]) begin
            status_zero[7:6] <= DCCU_TC_ABNORMAL;
            status_zero[DCCU_ST0_EC] <= 1'b1;
          end
        end
        if (state_q == DCCU_STEP && mode_rel_q && !dir_out && current_track_reg == 8'h00
            && pulse_q == 3'h0) begin
          status_zero[DCCU_ST0_EC] <= 1'b1;
          status_zero[7:6] <= DCCU_TC_ABNORMAL;
        end
        if (take && cmd_code == DCCU_CMD_READID) begin
          readid_q <= 1'b1;
          index_cnt_q <= 2'h0;
          missing_id_flag <= 1'b0;
        end else if (readid_q) begin
          if (id_found) begin
            readid_q <= 1'b0;
            irq <= 1'b1;
            status_zero <= {DCCU_TC_NORMAL, 6'h00};
          end else if (rotation_marker_input && !idx_prev_q) begin
            index_cnt_q <= index_cnt_q + 2'h1;
            if (index_cnt_q == 2'h1) begin
              readid_q <= 1'b0;
              missing_id_flag <= 1'b1;
              irq <= 1'b1;
              status_zero <= {DCCU_TC_ABNORMAL, 6'h00};
            end
          end
        end
        if (rw_byte_need && program_io_select) begin
          irq <= 1'b1;
        end
        if (take && cmd_code == DCCU_CMD_SENSEINT && state_q != DCCU_DONE) begin
          irq <= 1'b0;
          drive_busy <= 1'b0;
        end
      end
    end
  end

  // result byte path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result_byte <= 8'h00;
    end else if (clk_en) begin
      result_valid <= 1'b0;
      if (take) begin
        case (cmd_code)
          DCCU_CMD_SENSEINT: begin
            result_valid <= 1'b1;
            result_byte <= status_zero & ~(8'h01 << DCCU_ST0_HD);
          end
          DCCU_CMD_SENSEDRV: begin
            result_valid <= 1'b1;
            result_byte <= drive_status_in;
          end
          DCCU_CMD_VERSION: begin
            result_valid <= 1'b1;
            result_byte <= DCCU_VERSION_BYTE;
          end
          DCCU_CMD_READID: begin
            result_byte <= result_byte;
          end
          default: begin
            result_byte <= result_byte;
          end
        endcase
      end else if (readid_q && id_found) begin
        result_valid <= 1'b1;
        result_byte <= id_track;
      end
    end
  end
endmodule

// >>> dccu_core_assertions.sv
// dccu_core_chk: port-level checks for the command unit
module dccu_core_chk
  import dccu_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic clk_en, // clock enable
  input wire logic cmd_valid, // command strobe
  input wire dccu_cmd_t cmd_code, // command
  input wire logic [7:0] drive_status_in, // drive status
  input wire logic powerdown_exit, // leaving powerdown
  input wire logic rw_byte_need, // byte wanted
  input wire logic step_out, // step pulse
  input wire logic dir_out, // direction
  input wire logic busy, // command busy
  input wire logic irq, // interrupt
  input wire logic result_valid, // result strobe
  input wire logic [7:0] result_byte, // result
  input wire logic [7:0] current_track_reg, // track
  input wire logic [7:0] status_zero, // status zero
  input wire logic request_for_master, // pio request
  input wire logic transfer_irq_pin, // pio irq
  input wire logic dma_request_pin, // dma request
  input wire logic [4:0] queue_threshold_bytes, // threshold
  input wire logic program_io_select // pio mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic take;
  // a command only counts with the clock enabled
  assign take = cmd_valid && clk_en;
  property p_busy; busy == take; endproperty
  a_busy: assert property (p_busy) else $error("busy outside command phase");
  property p_pulse; $rose(step_out) |-> step_out [*4] ##1 !step_out; endproperty
  a_pulse: assert property (p_pulse) else $error("step pulse width wrong");
  property p_dir; $rose(step_out) |-> $stable(dir_out); endproperty
  a_dir: assert property (p_dir) else $error("direction moved at step");
  property p_gap; $fell(step_out) |-> !step_out [*8]; endproperty
  a_gap: assert property (p_gap) else $error("steps too close");
  property p_head; !status_zero[DCCU_ST0_HD]; endproperty
  a_head: assert property (p_head) else $error("head bit set");
  property p_thr; queue_threshold_bytes != 5'h00 && queue_threshold_bytes <= 5'h10; endproperty
  a_thr: assert property (p_thr) else $error("threshold out of range");
  property p_pio; rw_byte_need && program_io_select |-> request_for_master && transfer_irq_pin && !dma_request_pin;
  endproperty
  a_pio: assert property (p_pio) else $error("pio request wrong");
  property p_dma; rw_byte_need && !program_io_select |-> dma_request_pin && !request_for_master; endproperty
  a_dma: assert property (p_dma) else $error("dma request wrong");
  property p_ver; take && cmd_code == DCCU_CMD_VERSION |=> result_valid && result_byte == DCCU_VERSION_BYTE;
  endproperty
  a_ver: assert property (p_ver) else $error("version byte wrong");
  property p_drv; take && cmd_code == DCCU_CMD_SENSEDRV |=> result_valid && result_byte == $past(drive_status_in);
  endproperty
  a_drv: assert property (p_drv) else $error("drive status wrong");
  property p_irq; irq && !(take && cmd_code == DCCU_CMD_SENSEINT) && !powerdown_exit |=> irq; endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped early");
  property p_pwr; powerdown_exit && clk_en |=> current_track_reg == 8'h00 && status_zero == 8'h00; endproperty
  a_pwr: assert property (p_pwr) else $error("powerdown exit left state");
  c_step: cover property ($rose(step_out));
  c_irq: cover property ($rose(irq));
  c_res: cover property (result_valid);
endmodule

bind dccu_core dccu_core_chk u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .drive_status_in(drive_status_in), .powerdown_exit(powerdown_exit),
  .rw_byte_need(rw_byte_need), .step_out(step_out), .dir_out(dir_out), .busy(busy), .irq(irq),
  .result_valid(result_valid), .result_byte(result_byte), .current_track_reg(current_track_reg),
  .status_zero(status_zero), .request_for_master(request_for_master), .transfer_irq_pin(transfer_irq_pin),
  .dma_request_pin(dma_request_pin), .queue_threshold_bytes(queue_threshold_bytes),
  .program_io_select(program_io_select));

// >>> dccu_drive_model.sv
// dccu_drive_model: behavioural drive mechanism with head position and index
module dccu_drive_model (
  input wire logic clk, // clock
  input wire logic step_out, // step pulse
  input wire logic dir_out, // 1 in, 0 out
  output logic track_zero_input, // high at track zero
  output logic rotation_marker_input // index pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  int steps = 0;
  int idx = 0;
  logic stuck = 1'b0;
  logic prev = 1'b0;
  // stuck models a dead sensor so the step limit can be reached
  assign track_zero_input = (pos == 0) && !stuck;
  // head moves one track per rising step edge, stops at the outer stop of zero
  always @(posedge clk) begin
    prev <= step_out;
    if (step_out && !prev) begin
      steps <= steps + 1;
      if (dir_out) pos <= pos + 1;
      else if (pos > 0) pos <= pos - 1;
    end
  end
  // the disk spins all the time, so the index runs free
  always @(posedge clk) begin
    idx <= (idx == 2999) ? 0 : idx + 1;
  end
  assign rotation_marker_input = (idx == 0);
endmodule

// >>> tb_top.sv
// tb_top: directed tests of the command unit against a drive model
module tb_top
  import dccu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RSTEPS = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  dccu_cmd_t cmd_code = DCCU_CMD_NONE;
  logic [7:0] a0 = 8'h00;
  logic [7:0] a1 = 8'h00;
  logic [7:0] a2 = 8'h00;
  logic [7:0] dsi = 8'h00;
  logic pdx = 1'b0;
  logic rwn = 1'b0;
  logic tz, ix, step_out, dir_out, busy, drive_busy, irq, result_valid, missing_id_flag;
  logic request_for_master, transfer_irq_pin, dma_request_pin, auto_seek_enable, queue_disable, program_io_select;
  logic [7:0] result_byte, current_track_reg, status_zero, precomp_start_track, res_b;
  logic [4:0] queue_threshold_bytes;
  logic res_v;
  int mismatches = 0;
  int check_count = 0;

  // free-running 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // rate and enable held fixed; id reader idle so read id must fail
  dccu_core #(.RECAL_STEPS(RSTEPS)) dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg0(a0), .cmd_arg1(a1), .cmd_arg2(a2), .rate_shift(2'h3),
    .track_zero_input(tz), .rotation_marker_input(ix), .id_found(1'b0), .id_track(8'h00),
    .drive_status_in(dsi), .powerdown_exit(pdx), .rw_byte_need(rwn), .step_out(step_out), .dir_out(dir_out),
    .busy(busy), .drive_busy(drive_busy), .irq(irq), .result_valid(result_valid), .result_byte(result_byte),
    .current_track_reg(current_track_reg), .status_zero(status_zero), .missing_id_flag(missing_id_flag),
    .request_for_master(request_for_master), .transfer_irq_pin(transfer_irq_pin),
    .dma_request_pin(dma_request_pin), .head_loaded(), .settle_busy(), .auto_seek_enable(auto_seek_enable),
    .queue_disable(queue_disable), .queue_threshold_bytes(queue_threshold_bytes),
    .precomp_start_track(precomp_start_track), .program_io_select(program_io_select));

  dccu_drive_model drv (.clk(clk), .step_out(step_out), .dir_out(dir_out), .track_zero_input(tz),
    .rotation_marker_input(ix));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one command cycle; result is sampled right after the taking edge
  task automatic issue(input dccu_cmd_t c, input logic [7:0] x0, input logic [7:0] x1, input logic [7:0] x2);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    a0 = x0;
    a1 = x1;
    a2 = x2;
    #1;
    chk("busy", 8'h01, {7'h00, busy});
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    res_v = result_valid;
    res_b = result_byte;
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("irq", 8'h01, {7'h00, irq});
  endtask

  task automatic sense(input logic [1:0] code, input logic done, input logic fault);
    issue(DCCU_CMD_SENSEINT, 8'h00, 8'h00, 8'h00);
    chk("sense_valid", 8'h01, {7'h00, res_v});
    chk("sense_byte", {code, done, fault, 4'h0}, res_b & 8'hf4);
    chk("irq_clear", 8'h00, {7'h00, irq});
    chk("drive_free", 8'h00, {7'h00, drive_busy});
  endtask

  task automatic position(input dccu_cmd_t c, input logic [7:0] x0, input logic [7:0] x1, input logic d,
                          input logic [7:0] trk, input int n);
    drv.steps = 0;
    issue(c, x0, x1, 8'h00);
    chk("exec_not_busy", 8'h02, {6'h00, drive_busy, busy});
    wait_irq();
    chk("dir", {7'h00, d}, {7'h00, dir_out});
    chk("track", trk, current_track_reg);
    chk("steps", n[7:0], drv.steps[7:0]);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // about 70k cycles of stepping and index waits expected; stays under the run budget
  initial begin
    #(95000 * 40);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("irq_poll", 8'h01, {7'h00, irq});
    chk("cfg_default", 8'h41, {auto_seek_enable, queue_disable, program_io_select, queue_threshold_bytes});
    chk("precomp_default", 8'h00, precomp_start_track);
    sense(2'b11, 1'b0, 1'b0);
    issue(DCCU_CMD_VERSION, 8'h00, 8'h00, 8'h00);
    chk("version", DCCU_VERSION_BYTE, res_b);
    dsi = 8'h5a;
    issue(DCCU_CMD_SENSEDRV, 8'h00, 8'h00, 8'h00);
    chk("drive_status_valid", 8'h01, {7'h00, res_v});
    chk("drive_status", 8'h5a, res_b);
    // transfer signalling in dma and then program io mode
    rwn = 1'b1;
    issue(DCCU_CMD_SPECIFY, 8'hf1, 8'h02, 8'h00);
    chk("dma_mode", 8'h01, {4'h0, program_io_select, request_for_master, transfer_irq_pin, dma_request_pin});
    issue(DCCU_CMD_SPECIFY, 8'hf1, 8'h03, 8'h00);
    chk("pio_mode", 8'h0e, {4'h0, program_io_select, request_for_master, transfer_irq_pin, dma_request_pin});
    rwn = 1'b0;
    // extreme field values; polling switched off from here on
    issue(DCCU_CMD_CONFIG, 8'h00, 8'h5f, 8'hff);
    chk("cfg_set", 8'hb0, {auto_seek_enable, queue_disable, program_io_select, queue_threshold_bytes});
    chk("precomp_set", 8'hff, precomp_start_track);
    drv.pos = 2;
    position(DCCU_CMD_RECAL, 8'h00, 8'h00, 1'b0, 8'h00, 2);
    sense(2'b00, 1'b1, 1'b0);
    position(DCCU_CMD_SEEK, 8'h03, 8'h00, 1'b1, 8'h03, 3);
    sense(2'b00, 1'b1, 1'b0);
    position(DCCU_CMD_RELSEEK, 8'h01, 8'h00, 1'b0, 8'h02, 1);
    sense(2'b00, 1'b1, 1'b0);
    issue(DCCU_CMD_READID, 8'h00, 8'h00, 8'h00);
    wait_irq();
    chk("missing_id", 8'h05, {5'h00, missing_id_flag, status_zero[7:6]});
    pdx = 1'b1;
    @(posedge clk);
    #1;
    pdx = 1'b0;
    chk("pd_track", 8'h00, current_track_reg);
    chk("pd_status", 8'h00, status_zero);
    issue(DCCU_CMD_SENSEINT, 8'h00, 8'h00, 8'h00);
    drv.stuck = 1'b1;
    drv.pos = 20;
    position(DCCU_CMD_RECAL, 8'h00, 8'h00, 1'b0, 8'h00, RSTEPS);
    sense(2'b01, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule
